/* File: tb/mdsu_axi_master.sv */
// register bus master standing in for the decode and register-file side
module mdsu_axi_master
  import mdsu_pkg::*;
(
  input  wire logic              core_clk,
  output logic [ADDR_W-1:0]      s_axi_awaddr,
  output logic                   s_axi_awvalid,
  input  wire logic              s_axi_awready,
  output logic [31:0]            s_axi_wdata,
  output logic [3:0]             s_axi_wstrb,
  output logic                   s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  output logic                   s_axi_bready,
  output logic [ADDR_W-1:0]      s_axi_araddr,
  output logic                   s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [31:0]       s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  output logic                   s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idle until the bench asks; operand, control and status words are
  // all issued as the bench gives them, never a stack or program pointer
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 16'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
  end

  // one write, each channel held until its own ready
  // strobes default to the full word; partial ones exercise the merge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r, input logic [3:0] s = 4'hF);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;  // released lines must not keep the value
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // one read, data taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule

/* File: tb/tb_mdsu_unit.sv */
// self-checking bench for the multiply, divide and clamp unit
module tb_mdsu_unit
  import mdsu_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [31:0] ctrl, a, b, c;  // control, operands, accumulate and pair
    logic [7:0]  ra;             // where the result is read
    logic [31:0] e, eh;          // result and high word expected
    logic        q;              // sticky flag expected afterwards
  } mdsu_row_t;

  localparam logic [31:0] ones = 32'hFFFF_FFFF;
  localparam logic [31:0] m7 = 32'hFFFF_FFF9;  // minus seven

  // sticky flag is never cleared between rows, so q accumulates
  mdsu_row_t rows [18] = '{
    '{32'h0,ones,ones,32'h0,8'h14,32'h1,32'h0,1'b0},
    '{32'h1,ones,32'h2,32'h5,8'h14,32'h3,32'h5,1'b0},
    '{32'h2,32'h3,32'h4,32'hA,8'h14,32'hFFFF_FFFE,32'hA,1'b0},
    '{32'h3,ones,ones,32'h7,8'hC,32'h1,32'hFFFF_FFFE,1'b0},
    '{32'h4,ones,32'h2,32'h1,8'hC,ones,32'h2,1'b0},
    '{32'h5,ones,32'h2,32'h3,8'hC,32'hFFFF_FFFE,ones,1'b0},
    '{32'h6,ones,32'h2,32'h1,8'hC,ones,32'h0,1'b0},
    '{32'h7,m7,32'h2,32'h0,8'h14,32'hFFFF_FFFD,32'h0,1'b0},
    '{32'h8,m7,32'h2,32'h0,8'h14,32'h7FFF_FFFC,32'h0,1'b0},
    '{32'h8,32'h5,32'h0,32'h0,8'h14,32'h0,32'h0,1'b0},
    '{32'h47,32'h64,m7,32'h0,8'h0,32'hFFFF_FFF2,32'h0,1'b0},
    '{32'h41,32'h3,32'h4,32'h5,8'h0,32'h11,32'h5,1'b0},
    '{32'h8_0009,32'h0,32'h100,32'h0,8'h14,32'h7F,32'h0,1'b1},
    '{32'h10_0409,32'h0,32'h10,32'h0,8'h14,32'h100,32'h0,1'b1},
    '{32'h4_042A,32'h0,m7,32'h0,8'h14,32'h0,32'h0,1'b1},
    '{32'h4_000A,32'h0,32'h14,32'h0,8'h14,32'hF,32'h0,1'b1},
    '{32'h20_0009,32'h0,ones,32'h0,8'h14,ones,32'h0,1'b1},
    '{32'hA,32'h0,32'h0,32'h0,8'h14,32'h0,32'h0,1'b1}
  };

  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          fails = 0;
  int          check_count = 0;
  mdsu_row_t   w;  // row under test

  // 50 MHz core clock
  always #10ns core_clk = ~core_clk;

  mdsu_unit dut (
    .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  mdsu_axi_master far (
    .core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  // one comparison, case equality so unknowns never match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // counts, verdict, end of run
  task automatic results();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // write and compare the response code
  task automatic wrc(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er, input logic [3:0] s = 4'hF);
    logic [1:0] r;
    far.wr(a, d, r, s);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // read and compare data and response code
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    far.rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // poll busy under a bounded count; a divide needs some 35 cycles
  task automatic idle();
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'h1;
    for (int i = 0; i < 100 && d[ST_BUSY] !== 1'b0; i++)
      far.rd(OFS_STATUS, d, r);
    chk({31'h0, d[ST_BUSY]}, 32'h0);
  endtask

  // load operands, start, wait until done
  task automatic op(input logic [31:0] ctrl, a, b);
    wrc(OFS_MCAND, a, RESP_OKAY);
    wrc(OFS_MPLIER, b, RESP_OKAY);
    wrc(OFS_CTRL, ctrl | 32'h8000_0000, RESP_OKAY);
    idle();
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      rdc(8'(i * 4), RST_WORD, RESP_OKAY);
    foreach (rows[i]) begin
      w = rows[i];
      wrc(OFS_ACCUM, w.c, RESP_OKAY);
      wrc(OFS_LOWORD, w.c, RESP_OKAY);
      wrc(OFS_HIWORD, w.c, RESP_OKAY);
      op(w.ctrl, w.a, w.b);
      rdc(w.ra, w.e, RESP_OKAY);
      rdc(OFS_HIWORD, w.eh, RESP_OKAY);
      rdc(OFS_STATUS, {4'h0, w.q, 27'h0}, RESP_OKAY);
    end
    // status write clears the sticky flag even with its data bit set
    wrc(OFS_STATUS, 32'h3800_0000, RESP_OKAY);
    rdc(OFS_STATUS, 32'h3000_0000, RESP_OKAY);
    // flag form, issued unconditionally as the issuer must
    op(32'h10, ones, 32'h1);
    rdc(OFS_STATUS, 32'hB000_0000, RESP_OKAY);
    op(32'h10, 32'h0, 32'h5);
    rdc(OFS_STATUS, 32'h7000_0000, RESP_OKAY);
    op(32'h5, 32'h2, ones);
    rdc(OFS_STATUS, 32'h7000_0000, RESP_OKAY);
    op(32'h7, 32'h9, 32'h0);
    rdc(OFS_RESULT, 32'h0, RESP_OKAY);
    rdc(OFS_STATUS, 32'h7000_0000, RESP_OKAY);
    // control write during a divide must be ignored
    wrc(OFS_MCAND, m7, RESP_OKAY);
    wrc(OFS_MPLIER, 32'h2, RESP_OKAY);
    wrc(OFS_CTRL, 32'h8000_0007, RESP_OKAY);
    wrc(OFS_CTRL, 32'h8000_0008, RESP_OKAY);
    idle();
    rdc(OFS_RESULT, 32'hFFFF_FFFD, RESP_OKAY);
    rdc(OFS_CTRL, 32'h7, RESP_OKAY);
    // unmapped place and read-only result
    wrc(8'h20, 32'h1, RESP_SLVER);
    rdc(8'h20, 32'h0, RESP_SLVER);
    wrc(OFS_RESULT, 32'h5, RESP_OKAY);
    rdc(OFS_RESULT, 32'hFFFF_FFFD, RESP_OKAY);
    // one byte lane merges into the old word
    wrc(OFS_MCAND, 32'h0000_5A00, RESP_OKAY, 4'h2);
    rdc(OFS_MCAND, 32'hFFFF_5AF9, RESP_OKAY);
    // start bit without its byte strobe must not issue
    wrc(OFS_CTRL, 32'h8000_0000, RESP_OKAY, 4'h1);
    rdc(OFS_CTRL, 32'h0, RESP_OKAY);
    rdc(OFS_RESULT, 32'hFFFF_FFFD, RESP_OKAY);
    // reset in the first step of a divide
    wrc(OFS_CTRL, 32'h8000_0007, RESP_OKAY);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(OFS_STATUS, RST_WORD, RESP_OKAY);
    rdc(OFS_RESULT, RST_WORD, RESP_OKAY);
    results();
  end

  // watchdog, far beyond the expected length of the run
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    results();
  end
endmodule

/* File: verilog/mdsu_pkg.sv */
// constants, types and register map of the multiply, divide and clamp unit
// Operation
// - low product keeps low 32 bits
// - multiply, add accumulator, keep low word
// - accumulator minus product, keep low word
// - one datapath for signed and unsigned
// - no target means write to multiplicand (clamps ignore it and still write result_target)
// - flag form sets N, Z only
// - unsigned long product splits low/high words
// - unsigned long product accumulates into pair
// - signed long product splits low/high words
// - signed long product accumulates into pair
// - long products leave flags unchanged
// - quotient signed or unsigned by opcode
// - quotient truncates toward zero
// - divides leave flags unchanged
// - signed clamp width one to 32
// - unsigned clamp width zero to 31
// - optional arithmetic right or left shift
// - clamp that changes value sets sticky flag
// - only status write clears sticky flag
package mdsu_pkg;

  localparam int ADDR_W = 8;                  // register bus address width

  // register byte offsets
  localparam logic [7:0] OFS_MCAND  = 8'h00;  // multiplicand_source
  localparam logic [7:0] OFS_MPLIER = 8'h04;  // multiplier_source
  localparam logic [7:0] OFS_ACCUM  = 8'h08;  // accumulate_source
  localparam logic [7:0] OFS_LOWORD = 8'h0C;  // low_word_target
  localparam logic [7:0] OFS_HIWORD = 8'h10;  // high_word_target
  localparam logic [7:0] OFS_RESULT = 8'h14;  // result_target, read only
  localparam logic [7:0] OFS_CTRL   = 8'h18;  // operation control
  localparam logic [7:0] OFS_STATUS = 8'h1C;  // app_status_word

  // control field positions
  localparam int CTRL_OP_LSB   = 0;           // opcode, 4 bits
  localparam int CTRL_FLAGSET  = 4;           // flag-setting product form
  localparam int CTRL_SH_ARITH = 5;           // 1: arith right, 0: left
  localparam int CTRL_NO_DEST  = 6;           // no separate result target
  localparam int CTRL_SH_LSB   = 8;           // shift amount, 5 bits
  localparam int CTRL_SAT_LSB  = 16;          // clamp width, 6 bits
  localparam int CTRL_START    = 31;          // start, reads as zero

  // status field positions
  localparam int ST_FLAG_N = 31;
  localparam int ST_FLAG_Z = 30;
  localparam int ST_FLAG_C = 29;
  localparam int ST_FLAG_V = 28;
  localparam int ST_FLAG_Q = 27;              // sticky saturation flag
  localparam int ST_BUSY   = 0;

  // reset values and counts
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [4:0]  DIV_STEPS  = 5'h1F; // last step index of 32
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVER = 2'h2;

  typedef enum logic [3:0] {
    OP_PRODUCT_LOW  = 4'b0000,
    OP_PRODUCT_ADD  = 4'b0001,
    OP_PRODUCT_SUB  = 4'b0010,
    OP_ULONG        = 4'b0011,
    OP_ULONG_ACC    = 4'b0100,
    OP_SLONG        = 4'b0101,
    OP_SLONG_ACC    = 4'b0110,
    OP_SQUOT        = 4'b0111,
    OP_UQUOT        = 4'b1000,
    OP_SCLAMP       = 4'b1001,
    OP_UCLAMP       = 4'b1010
  } mdsu_op_t;

  typedef enum logic [1:0] {
    DV_IDLE = 2'b00,
    DV_STEP = 2'b01,
    DV_DONE = 2'b10
  } mdsu_div_state_t;

endpackage

/* File: verilog/mdsu_unit.sv */
// multiply, divide and clamp unit with its register bus slave
//
// Chosen here: the AXI4-Lite register port and the address map.
module mdsu_unit
  import mdsu_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // architectural registers
  logic [31:0] mcand;          // multiplicand_source
  logic [31:0] mplier;         // multiplier_source
  logic [31:0] accum;          // accumulate_source
  logic [31:0] lo_word;        // low_word_target
  logic [31:0] hi_word;        // high_word_target
  logic [31:0] result;         // result_target
  logic [31:0] ctrl;           // control fields, start not stored
  logic        flag_n;         // negative
  logic        flag_z;         // zero
  logic        flag_c;         // carry, never touched by arithmetic here
  logic        flag_v;         // overflow, never touched by arithmetic here
  logic        flag_q;         // sticky saturation

  // bus bookkeeping
  logic [7:0]  aw_addr;        // held write address
  logic [31:0] w_data;         // held write data
  logic [3:0]  w_strb;         // held byte strobes
  logic        wr_fire;        // both halves held, response free
  logic        wr_mapped;      // held write address decodes
  logic [7:0]  ar_word;        // read address forced to a word
  logic        op_go;          // one-cycle issue pulse
  logic        busy;           // issue or divide in progress

  // divider state
  mdsu_div_state_t div_state;
  logic [31:0] div_rem;        // partial remainder
  logic [31:0] div_quo;        // dividend shifting into quotient
  logic [31:0] div_dvs;        // divisor magnitude
  logic [4:0]  div_cnt;        // step index
  logic        div_neg;        // quotient sign must flip
  logic        div_zero;       // divisor was zero
  logic        div_nodest;     // write to multiplicand when done
  logic [32:0] div_trial;      // trial subtraction
  logic [31:0] div_final;      // signed-corrected quotient

  // combinational datapath
  mdsu_op_t    op;
  logic [63:0] prod_u;         // unsigned 64-bit product
  logic [63:0] prod_s;         // signed 64-bit product
  logic [31:0] shifted;        // clamp input after shift
  logic signed [63:0] sx;      // shifted value widened
  logic signed [63:0] sat_hi;  // upper clamp bound
  logic signed [63:0] sat_lo;  // lower clamp bound
  logic signed [63:0] clamped; // bounded value
  logic        sat_hit;        // clamp changed the value
  logic [5:0]  sat_w;          // width forced into legal range
  logic [5:0]  n_field;        // raw width field

  localparam logic signed [63:0] ONE64 = 64'sh0000_0000_0000_0001;

  assign op        = mdsu_op_t'(ctrl[CTRL_OP_LSB +: 4]);
  assign n_field   = ctrl[CTRL_SAT_LSB +: 6];
  assign busy      = op_go || (div_state != DV_IDLE);
  assign wr_fire   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign ar_word   = {s_axi_araddr[7:2], 2'b00};
  assign wr_mapped = (aw_addr <= OFS_STATUS);

  // byte-lane merge of a bus write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  stb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction

  // products: low 32 bits equal for either signedness, so one path
  assign prod_u = {32'h0000_0000, mcand} * {32'h0000_0000, mplier};
  assign prod_s = 64'($signed(mcand) * $signed(mplier));

  // clamp datapath: shift then bound
  always_comb begin
    if (ctrl[CTRL_SH_ARITH]) begin
      shifted = 32'($signed(mplier) >>> ctrl[CTRL_SH_LSB +: 5]);
    end else begin
      shifted = mplier << ctrl[CTRL_SH_LSB +: 5];
    end
    sx = 64'($signed(shifted));
    if (op == OP_SCLAMP) begin
      // width 0 or above 32 is illegal; forced to nearest legal width
      sat_w  = (n_field == 6'h00) ? 6'h01 :
               (n_field > 6'h20) ? 6'h20 : n_field;
      sat_hi = (ONE64 <<< (sat_w - 6'h01)) - ONE64;
      sat_lo = -sat_hi - ONE64;
    end else begin
      sat_w  = (n_field > 6'h1F) ? 6'h1F : n_field;
      sat_hi = (ONE64 <<< sat_w) - ONE64;
      sat_lo = '0;
    end
    if (sx > sat_hi) begin
      clamped = sat_hi;
    end else if (sx < sat_lo) begin
      clamped = sat_lo;
    end else begin
      clamped = sx;
    end
    sat_hit = (clamped != sx);
  end

  // write address channel: ready falls while an address is held
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      aw_addr       <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr       <= {s_axi_awaddr[7:2], 2'b00};
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel, independent of the address
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b1;
      w_data       <= RST_WORD;
      w_strb       <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVER;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= RST_WORD;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (ar_word)
        OFS_MCAND:  s_axi_rdata <= mcand;
        OFS_MPLIER: s_axi_rdata <= mplier;
        OFS_ACCUM:  s_axi_rdata <= accum;
        OFS_LOWORD: s_axi_rdata <= lo_word;
        OFS_HIWORD: s_axi_rdata <= hi_word;
        OFS_RESULT: s_axi_rdata <= result;
        OFS_CTRL:   s_axi_rdata <= ctrl;
        OFS_STATUS: begin
          // status read shows flags and busy
          s_axi_rdata <= {flag_n, flag_z, flag_c, flag_v, flag_q,
                          26'h000_0000, busy};
        end
        default: begin
          s_axi_rdata <= RST_WORD;
          s_axi_rresp <= RESP_SLVER;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // control register and issue pulse; a start while busy is dropped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl  <= RST_WORD;
      op_go <= 1'b0;
    end else begin
      op_go <= 1'b0;
      if (wr_fire && aw_addr == OFS_CTRL && !busy) begin
        ctrl  <= merge(ctrl, w_data, w_strb) & 32'h7FFF_FFFF;
        op_go <= w_strb[3] && w_data[CTRL_START];
      end
    end
  end

  // operand and target registers; unit results win over a bus write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mcand   <= RST_WORD;
      mplier  <= RST_WORD;
      accum   <= RST_WORD;
      lo_word <= RST_WORD;
      hi_word <= RST_WORD;
      result  <= RST_WORD;
    end else begin
      if (wr_fire) begin
        case (aw_addr)
          OFS_MCAND:  mcand   <= merge(mcand, w_data, w_strb);
          OFS_MPLIER: mplier  <= merge(mplier, w_data, w_strb);
          OFS_ACCUM:  accum   <= merge(accum, w_data, w_strb);
          OFS_LOWORD: lo_word <= merge(lo_word, w_data, w_strb);
          OFS_HIWORD: hi_word <= merge(hi_word, w_data, w_strb);
          default: ;
        endcase
      end
      if (op_go) begin
        case (op)
          OP_PRODUCT_LOW, OP_PRODUCT_ADD, OP_PRODUCT_SUB: begin
            // low word is sign independent
            if (ctrl[CTRL_NO_DEST]) begin
              mcand <= (op == OP_PRODUCT_LOW) ? prod_u[31:0] :
                       (op == OP_PRODUCT_ADD) ? prod_u[31:0] + accum :
                       accum - prod_u[31:0];
            end else begin
              result <= (op == OP_PRODUCT_LOW) ? prod_u[31:0] :
                        (op == OP_PRODUCT_ADD) ? prod_u[31:0] + accum :
                        accum - prod_u[31:0];
            end
          end
          OP_ULONG: {hi_word, lo_word} <= prod_u;
          OP_ULONG_ACC: begin
            {hi_word, lo_word} <= {hi_word, lo_word} + prod_u;
          end
          OP_SLONG: {hi_word, lo_word} <= prod_s;
          OP_SLONG_ACC: begin
            // two's complement add is the same adder
            {hi_word, lo_word} <= {hi_word, lo_word} + prod_s;
          end
          OP_SCLAMP, OP_UCLAMP: result <= clamped[31:0];
          default: ;
        endcase
      end
      if (div_state == DV_DONE) begin
        if (div_nodest) begin
          mcand <= div_final;
        end else begin
          result <= div_final;
        end
      end
    end
  end

  // condition flags; besides a status write, only the flag form of the low product moves N, Z
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      flag_c <= 1'b0;
      flag_v <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      if (wr_fire && aw_addr == OFS_STATUS && w_strb[3]) begin
        flag_n <= w_data[ST_FLAG_N];
        flag_z <= w_data[ST_FLAG_Z];
        flag_c <= w_data[ST_FLAG_C];
        flag_v <= w_data[ST_FLAG_V];
        flag_q <= 1'b0;
      end
      if (op_go && op == OP_PRODUCT_LOW && ctrl[CTRL_FLAGSET]) begin
        flag_n <= prod_u[31];
        flag_z <= (prod_u[31:0] == 32'h0000_0000);
      end
      // a saturation in the clearing cycle still sets the flag
      if (op_go && (op == OP_SCLAMP || op == OP_UCLAMP) && sat_hit) begin
        flag_q <= 1'b1;
      end
    end
  end

  // restoring divider on magnitudes, 32 steps; flags never touched
  assign div_trial = {div_rem, div_quo[31]} - {1'b0, div_dvs};
  assign div_final = div_zero ? 32'h0000_0000 :
                     div_neg ? -div_quo : div_quo;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_state  <= DV_IDLE;
      div_rem    <= RST_WORD;
      div_quo    <= RST_WORD;
      div_dvs    <= RST_WORD;
      div_cnt    <= 5'h00;
      div_neg    <= 1'b0;
      div_zero   <= 1'b0;
      div_nodest <= 1'b0;
    end else begin
      case (div_state)
        DV_IDLE: begin
          if (op_go && (op == OP_SQUOT || op == OP_UQUOT)) begin
            // signed case divides magnitudes
            if (op == OP_SQUOT) begin
              div_quo <= mcand[31] ? -mcand : mcand;
              div_dvs <= mplier[31] ? -mplier : mplier;
              div_neg <= mcand[31] ^ mplier[31];
            end else begin
              div_quo <= mcand;
              div_dvs <= mplier;
              div_neg <= 1'b0;
            end
            div_rem    <= RST_WORD;
            div_cnt    <= 5'h00;
            div_zero   <= (mplier == 32'h0000_0000);
            div_nodest <= ctrl[CTRL_NO_DEST];
            div_state  <= DV_STEP;
          end
        end
        DV_STEP: begin
          if (!div_trial[32]) begin
            div_rem <= div_trial[31:0];
          end else begin
            div_rem <= {div_rem[30:0], div_quo[31]};
          end
          div_quo <= {div_quo[30:0], ~div_trial[32]};
          div_cnt <= div_cnt + 5'h01;
          if (div_cnt == DIV_STEPS) begin
            div_state <= DV_DONE;
          end
        end
        DV_DONE: div_state <= DV_IDLE;
        default: div_state <= DV_IDLE;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_low_product: assert property (
    op_go && op == OP_PRODUCT_LOW && !ctrl[CTRL_NO_DEST] |=>
      result == 32'($past(mcand) * $past(mplier)))
    else $error("low product result wrong");

  chk_product_sub: assert property (
    op_go && op == OP_PRODUCT_SUB && !ctrl[CTRL_NO_DEST] |=>
      result == $past(accum) - 32'($past(mcand) * $past(mplier)))
    else $error("product subtract result wrong");

  chk_no_dest: assert property (
    op_go && op == OP_PRODUCT_ADD && ctrl[CTRL_NO_DEST] |=>
      mcand == 32'($past(mcand) * $past(mplier)) + $past(accum)
      && $stable(result))
    else $error("product add did not return to multiplicand");

  chk_flag_form: assert property (
    op_go && op == OP_PRODUCT_LOW && ctrl[CTRL_FLAGSET] |=>
      flag_z == (result == 32'h0000_0000 && !$past(ctrl[CTRL_NO_DEST])
                 || mcand == 32'h0000_0000 && $past(ctrl[CTRL_NO_DEST]))
      && $stable(flag_c) && $stable(flag_v))
    else $error("flag form updated wrong flags");

  chk_signed_long: assert property (
    op_go && op == OP_SLONG |=>
      {hi_word, lo_word} == 64'($signed($past(mcand))
                                * $signed($past(mplier))))
    else $error("signed long product wrong");

  chk_uacc_long: assert property (
    op_go && op == OP_ULONG_ACC |=>
      {hi_word, lo_word} == {$past(hi_word), $past(lo_word)}
        + {32'h0000_0000, $past(mcand)} * {32'h0000_0000, $past(mplier)})
    else $error("unsigned long accumulate wrong");

  chk_long_flags: assert property (
    op_go && op inside {OP_ULONG, OP_ULONG_ACC, OP_SLONG, OP_SLONG_ACC}
      |=> $stable(flag_n) && $stable(flag_z) && $stable(flag_q))
    else $error("long product moved a flag");

  chk_div_time: assert property (
    op_go && op == OP_UQUOT |=> div_state == DV_STEP && div_cnt == 5'h00
      ##31 div_state == DV_STEP && div_cnt == DIV_STEPS
      ##1 div_state == DV_DONE ##1 $stable(flag_n) && $stable(flag_z))
    else $error("divide timing or flags wrong");

  chk_unsigned_quotient_op_value: assert property (
    op_go && op == OP_UQUOT && mplier != 32'h0000_0000
      && !ctrl[CTRL_NO_DEST] |-> ##35
      result == $past(mcand, 35) / $past(mplier, 35))
    else $error("unsigned quotient wrong");

  chk_div_zero: assert property (
    div_state == DV_DONE && div_zero && !div_nodest |=>
      result == 32'h0000_0000)
    else $error("zero divisor quotient not zero");

  chk_sat_sets: assert property (
    op_go && op inside {OP_SCLAMP, OP_UCLAMP} && sat_hit |=> flag_q)
    else $error("saturation did not set sticky flag");

  chk_sticky_hold: assert property (
    $fell(flag_q) |-> $past(wr_fire && aw_addr == OFS_STATUS))
    else $error("sticky flag cleared without status write");

endmodule
